// ### logic/ulcr_baud.sv
// Baud divider producing the 16x oversampling enable pulse
`timescale 1ns/10ps
`default_nettype none

module ulcr_baud #(
    parameter int DIV_W = 16
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [DIV_W-1:0] divisor,
    output logic tick
);

    ulcr_pkg::ulcr_baud_state_type s_r;
    ulcr_pkg::ulcr_baud_state_type s_nxt;

    // Count 2*divisor core cycles per tick; a zero divisor halts the tick
    always_comb begin
        s_nxt = s_r;
        s_nxt.tick = 1'b0;
        if (divisor == '0) begin
            s_nxt.count = '0;
        end else if (s_r.count == 17'h00000) begin
            s_nxt.count = {divisor, 1'b0} - 17'h00001;
            s_nxt.tick = 1'b1;
        end else begin
            s_nxt.count = s_r.count - 17'h00001;
        end
    end

    // State register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign tick = s_r.tick;

endmodule

`default_nettype wire

// ### logic/ulcr_defines.svh
// Register map, field positions, reset values and timing counts of the UART block
`ifndef ULCR_DEFINES_SVH
`define ULCR_DEFINES_SVH

// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define ULCR_ADDR_DATA 32'hFFFF0700
`define ULCR_ADDR_DLM_IER 32'hFFFF0704
`define ULCR_ADDR_LCR 32'hFFFF070C
`define ULCR_ADDR_PCR 32'hFFFF0710
`define ULCR_ADDR_LSR 32'hFFFF0714

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define ULCR_RST_BYTE 8'h00
`define ULCR_RST_LSR 8'h60

// ----------------------------------------------------------------
// line_control fields
// ----------------------------------------------------------------
`define ULCR_LCR_DIVISOR_ACCESS_SELECT 7
`define ULCR_LCR_BRK 6
`define ULCR_LCR_SP 5
`define ULCR_LCR_EPS 4
`define ULCR_LCR_PEN 3
`define ULCR_LCR_STOP 2
`define ULCR_LCR_WLS_HI 1
`define ULCR_LCR_WLS_LO 0

// ----------------------------------------------------------------
// port_control fields and input mux codes
// ----------------------------------------------------------------
`define ULCR_PCR_MUX_HI 7
`define ULCR_PCR_MUX_LO 6
`define ULCR_PCR_LOOP 4
`define ULCR_MUX_LIN 2'h0
`define ULCR_MUX_GPIO 2'h2

// ----------------------------------------------------------------
// Oversampling counts in 16x ticks, and the last data bit index for five-bit words
// ----------------------------------------------------------------
`define ULCR_TICK_LAST 4'hF
`define ULCR_TICK_HALF 4'h7
`define ULCR_STOP_ONE 6'h10
`define ULCR_STOP_ONE_HALF 6'h18
`define ULCR_STOP_TWO 6'h20
`define ULCR_MIN_BITS 3'h4

// ----------------------------------------------------------------
// AXI responses
// ----------------------------------------------------------------
`define ULCR_RESP_OKAY 2'h0
`define ULCR_RESP_SLVERR 2'h2

`endif

// ### logic/ulcr_pkg.sv
// Types shared by the UART register block modules
package ulcr_pkg;

    // ----------------------------------------------------------------
    // Register selected by an address and the divisor access bit
    // ----------------------------------------------------------------
    typedef enum {
        REG_NONE, REG_DATA, REG_DLL, REG_IER, REG_DLM, REG_LCR, REG_PCR, REG_LSR
    } ulcr_reg_type;

    // ----------------------------------------------------------------
    // Serial engine states
    // ----------------------------------------------------------------
    typedef enum {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} ulcr_tx_state_type;
    typedef enum {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} ulcr_rx_state_type;

    // ----------------------------------------------------------------
    // Baud divider state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [16:0] count;
        logic tick;
    } ulcr_baud_state_type;

endpackage

// ### logic/ulcr_top.sv
// UART line control registers with serial transmitter and receiver behind AXI4-Lite
//
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/10ps
`default_nettype none
`include "ulcr_defines.svh"

// Contract
// - Writing the data address with divisor access clear sends that byte serially.
// - Reading the data address with divisor access clear returns the last character.
// - Divisor low byte is read/write, resets zero, shares the data address.
// - Divisor high byte is read/write, resets zero, sets baud with low byte.
// - Divisor access set selects divisor bytes; clear selects data and enable regs.
// - Force break holds the serial output low until cleared; with loopback set, txd is held high instead.
// - Stick parity with parity enable forces parity to the even select value.
// - Even select picks even parity when set, odd when clear, both directions.
// - Parity enable adds a transmitted parity bit and receive checking.
// - Stop control set gives 1.5 stops for five bits, else two stops.
// - Stop control clear gives exactly one stop bit.
// - Receiver validates only the first stop bit.
// - Input select 00 takes the LIN input, 10 the GPIO pin five.
// - Loopback set enters loopback and holds the external output high.
// - Line status is read-only current status, resetting to 0x60.
// - Receive-full sets on a new character, clears on a buffer read.
// - Empty flags track holding and shift registers; a holding write clears both.
// - Framing error sets on a bad stop bit, clears automatically.
// - Overrun sets when an unread character is overwritten, clears automatically.
module ulcr_top (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic lin_rx,
    input wire logic gpio_pin_five,
    output logic txd
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic aw_held;
        logic [31:0] awaddr;
        logic w_held;
        logic [7:0] wdata;
        logic wlane;
        logic aw_rdy;
        logic w_rdy;
        logic bvalid;
        logic [1:0] bresp;
        logic ar_rdy;
        logic rvalid;
        logic [1:0] rresp;
        logic [7:0] rdata;
        logic [7:0] line_control;
        logic [7:0] port_control;
        logic [7:0] interrupt_enable_reg;
        logic [7:0] baud_divisor_low;
        logic [7:0] baud_divisor_high;
        logic [7:0] tx_holding;
        logic thr_full;
        ulcr_pkg::ulcr_tx_state_type tx_st;
        logic [7:0] tx_sh;
        logic [5:0] tx_cnt;
        logic [2:0] tx_bit;
        logic tx_par;
        logic tx_line;
        logic txd;
        ulcr_pkg::ulcr_rx_state_type rx_st;
        logic [3:0] rx_cnt;
        logic [2:0] rx_bit;
        logic [7:0] rx_sh;
        logic rx_pb;
        logic [7:0] rx_buffer;
        logic receive_full_flag;
        logic overrun;
        logic parity_err;
        logic framing_error;
        logic break_ind;
    } ulcr_top_state_type;

    ulcr_top_state_type s_r;
    ulcr_top_state_type s_nxt;
    logic tick;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    // Address decode shared by the read and write paths
    function automatic ulcr_pkg::ulcr_reg_type reg_decode(input logic [31:0] addr,
                                                           input logic divisor_access_select);
        reg_decode = ulcr_pkg::REG_NONE;
        case (addr)
            `ULCR_ADDR_DATA: reg_decode = divisor_access_select ? ulcr_pkg::REG_DLL : ulcr_pkg::REG_DATA;
            `ULCR_ADDR_DLM_IER: reg_decode = divisor_access_select ? ulcr_pkg::REG_DLM : ulcr_pkg::REG_IER;
            `ULCR_ADDR_LCR: reg_decode = ulcr_pkg::REG_LCR;
            `ULCR_ADDR_PCR: reg_decode = ulcr_pkg::REG_PCR;
            `ULCR_ADDR_LSR: reg_decode = ulcr_pkg::REG_LSR;
            default: reg_decode = ulcr_pkg::REG_NONE;
        endcase
    endfunction

    // Parity bit for the active data bits; used by both directions
    function automatic logic parity_of(input logic [7:0] data, input logic [7:0] lcr);
        logic [7:0] mask;
        mask = 8'hFF >> (2'h3 - lcr[`ULCR_LCR_WLS_HI:`ULCR_LCR_WLS_LO]);
        if (lcr[`ULCR_LCR_SP]) begin
            parity_of = lcr[`ULCR_LCR_EPS];
        end else if (lcr[`ULCR_LCR_EPS]) begin
            parity_of = ^(data & mask);
        end else begin
            parity_of = ~^(data & mask);
        end
    endfunction

    // ----------------------------------------------------------------
    // Baud tick
    // ----------------------------------------------------------------
    ulcr_baud #(
        .DIV_W(16)
    ) u_baud (
        .aclk(aclk),
        .aresetn(aresetn),
        .divisor({s_r.baud_divisor_high, s_r.baud_divisor_low}),
        .tick(tick)
    );

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        ulcr_pkg::ulcr_reg_type wsel;
        ulcr_pkg::ulcr_reg_type rsel;
        logic [7:0] lcr;
        logic [2:0] last_bit;
        logic [5:0] stop_ticks;
        logic rxd;
        logic do_write;
        logic rd_accept;
        logic clr_ready;
        logic clr_errs;
        s_nxt = s_r;
        lcr = s_r.line_control;
        last_bit = `ULCR_MIN_BITS + {1'b0, lcr[`ULCR_LCR_WLS_HI:`ULCR_LCR_WLS_LO]};
        clr_ready = 1'b0;
        clr_errs = 1'b0;

        // Write channel capture; address and data may come in either order
        if (s_r.aw_rdy && s_axi_awvalid) begin
            s_nxt.aw_held = 1'b1;
            s_nxt.awaddr = s_axi_awaddr;
        end
        if (s_r.w_rdy && s_axi_wvalid) begin
            s_nxt.w_held = 1'b1;
            s_nxt.wdata = s_axi_wdata[7:0];
            s_nxt.wlane = s_axi_wstrb[0];
        end
        if (s_r.bvalid && s_axi_bready) begin
            s_nxt.bvalid = 1'b0;
        end

        // Register write once both halves are held
        do_write = s_r.aw_held && s_r.w_held && !s_r.bvalid;
        wsel = reg_decode(s_r.awaddr, lcr[`ULCR_LCR_DIVISOR_ACCESS_SELECT]);
        if (do_write) begin
            s_nxt.aw_held = 1'b0;
            s_nxt.w_held = 1'b0;
            s_nxt.bvalid = 1'b1;
            s_nxt.bresp = (wsel == ulcr_pkg::REG_NONE) ? `ULCR_RESP_SLVERR : `ULCR_RESP_OKAY;
            if (s_r.wlane) begin
                case (wsel)
                    ulcr_pkg::REG_DATA: begin
                        s_nxt.tx_holding = s_r.wdata;
                        s_nxt.thr_full = 1'b1;
                    end
                    ulcr_pkg::REG_DLL: s_nxt.baud_divisor_low = s_r.wdata;
                    ulcr_pkg::REG_DLM: s_nxt.baud_divisor_high = s_r.wdata;
                    ulcr_pkg::REG_IER: s_nxt.interrupt_enable_reg = s_r.wdata;
                    ulcr_pkg::REG_LCR: s_nxt.line_control = s_r.wdata;
                    ulcr_pkg::REG_PCR: s_nxt.port_control = s_r.wdata;
                    default: s_nxt.bresp = s_nxt.bresp; // Status is read-only
                endcase
            end
        end

        // Read channel; side effects happen when the address is taken
        rd_accept = s_r.ar_rdy && s_axi_arvalid;
        rsel = reg_decode(s_axi_araddr, lcr[`ULCR_LCR_DIVISOR_ACCESS_SELECT]);
        if (s_r.rvalid && s_axi_rready) begin
            s_nxt.rvalid = 1'b0;
        end
        if (rd_accept) begin
            s_nxt.rvalid = 1'b1;
            s_nxt.rresp = (rsel == ulcr_pkg::REG_NONE) ? `ULCR_RESP_SLVERR : `ULCR_RESP_OKAY;
            case (rsel)
                ulcr_pkg::REG_DATA: begin
                    s_nxt.rdata = s_r.rx_buffer;
                    clr_ready = 1'b1;
                end
                ulcr_pkg::REG_DLL: s_nxt.rdata = s_r.baud_divisor_low;
                ulcr_pkg::REG_DLM: s_nxt.rdata = s_r.baud_divisor_high;
                ulcr_pkg::REG_IER: s_nxt.rdata = s_r.interrupt_enable_reg;
                ulcr_pkg::REG_LCR: s_nxt.rdata = s_r.line_control;
                ulcr_pkg::REG_PCR: s_nxt.rdata = s_r.port_control;
                ulcr_pkg::REG_LSR: begin
                    s_nxt.rdata = {1'b0, !s_r.thr_full && (s_r.tx_st == ulcr_pkg::TX_IDLE),
                                   !s_r.thr_full, s_r.break_ind, s_r.framing_error,
                                   s_r.parity_err, s_r.overrun, s_r.receive_full_flag};
                    clr_errs = 1'b1;
                end
                default: s_nxt.rdata = `ULCR_RST_BYTE;
            endcase
        end

        // Read clears first, so a same-cycle receive event below wins
        if (clr_ready) begin
            s_nxt.receive_full_flag = 1'b0;
        end
        if (clr_errs) begin
            s_nxt.overrun = 1'b0;
            s_nxt.parity_err = 1'b0;
            s_nxt.framing_error = 1'b0;
            s_nxt.break_ind = 1'b0;
        end

        // Transmitter: a 16-tick start bit, data LSB first, parity, stops
        if (lcr[`ULCR_LCR_STOP]) begin
            stop_ticks = (lcr[`ULCR_LCR_WLS_HI:`ULCR_LCR_WLS_LO] == 2'h0) ?
                         `ULCR_STOP_ONE_HALF : `ULCR_STOP_TWO;
        end else begin
            stop_ticks = `ULCR_STOP_ONE;
        end
        case (s_r.tx_st)
            ulcr_pkg::TX_IDLE: begin
                if (s_r.thr_full && !(do_write && wsel == ulcr_pkg::REG_DATA)) begin
                    s_nxt.tx_sh = s_r.tx_holding;
                    s_nxt.thr_full = 1'b0;
                    s_nxt.tx_cnt = '0;
                    s_nxt.tx_bit = '0;
                    s_nxt.tx_st = ulcr_pkg::TX_START;
                end
            end
            ulcr_pkg::TX_START: begin
                if (tick) begin
                    s_nxt.tx_cnt = s_r.tx_cnt + 6'h01;
                    if (s_r.tx_cnt[3:0] == `ULCR_TICK_LAST) begin
                        s_nxt.tx_cnt = '0;
                        s_nxt.tx_par = parity_of(s_r.tx_sh, lcr);
                        s_nxt.tx_st = ulcr_pkg::TX_DATA;
                    end
                end
            end
            ulcr_pkg::TX_DATA: begin
                if (tick) begin
                    s_nxt.tx_cnt = s_r.tx_cnt + 6'h01;
                    if (s_r.tx_cnt[3:0] == `ULCR_TICK_LAST) begin
                        s_nxt.tx_cnt = '0;
                        s_nxt.tx_sh = {1'b0, s_r.tx_sh[7:1]};
                        s_nxt.tx_bit = s_r.tx_bit + 3'h1;
                        if (s_r.tx_bit == last_bit) begin
                            s_nxt.tx_st = lcr[`ULCR_LCR_PEN] ? ulcr_pkg::TX_PAR
                                                             : ulcr_pkg::TX_STOP;
                        end
                    end
                end
            end
            ulcr_pkg::TX_PAR: begin
                if (tick) begin
                    s_nxt.tx_cnt = s_r.tx_cnt + 6'h01;
                    if (s_r.tx_cnt[3:0] == `ULCR_TICK_LAST) begin
                        s_nxt.tx_cnt = '0;
                        s_nxt.tx_st = ulcr_pkg::TX_STOP;
                    end
                end
            end
            ulcr_pkg::TX_STOP: begin
                if (tick) begin
                    s_nxt.tx_cnt = s_r.tx_cnt + 6'h01;
                    if (s_r.tx_cnt + 6'h01 >= stop_ticks) begin
                        s_nxt.tx_st = ulcr_pkg::TX_IDLE;
                    end
                end
            end
            default: s_nxt.tx_st = ulcr_pkg::TX_IDLE;
        endcase

        // Line level from the next engine state, then break and loopback
        case (s_nxt.tx_st)
            ulcr_pkg::TX_START: s_nxt.tx_line = 1'b0;
            ulcr_pkg::TX_DATA: s_nxt.tx_line = s_nxt.tx_sh[0];
            ulcr_pkg::TX_PAR: s_nxt.tx_line = s_nxt.tx_par;
            default: s_nxt.tx_line = 1'b1;
        endcase
        if (s_nxt.line_control[`ULCR_LCR_BRK]) begin
            s_nxt.tx_line = 1'b0;
        end
        s_nxt.txd = s_nxt.port_control[`ULCR_PCR_LOOP] ? 1'b1 : s_nxt.tx_line;

        // Receive source; reserved mux codes read as an idle line
        if (s_r.port_control[`ULCR_PCR_LOOP]) begin
            rxd = s_r.tx_line;
        end else begin
            case (s_r.port_control[`ULCR_PCR_MUX_HI:`ULCR_PCR_MUX_LO])
                `ULCR_MUX_LIN: rxd = lin_rx;
                `ULCR_MUX_GPIO: rxd = gpio_pin_five;
                default: rxd = 1'b1;
            endcase
        end

        // Receiver: centre-sampled bits at 16 ticks apart
        case (s_r.rx_st)
            ulcr_pkg::RX_IDLE: begin
                if (tick && !rxd) begin
                    s_nxt.rx_cnt = '0;
                    s_nxt.rx_bit = '0;
                    s_nxt.rx_sh = '0;
                    s_nxt.rx_st = ulcr_pkg::RX_START;
                end
            end
            ulcr_pkg::RX_START: begin
                if (tick) begin
                    s_nxt.rx_cnt = s_r.rx_cnt + 4'h1;
                    if (s_r.rx_cnt == `ULCR_TICK_HALF) begin
                        s_nxt.rx_cnt = '0;
                        // A glitch shorter than half a bit is not a start
                        s_nxt.rx_st = rxd ? ulcr_pkg::RX_IDLE : ulcr_pkg::RX_DATA;
                    end
                end
            end
            ulcr_pkg::RX_DATA: begin
                if (tick) begin
                    s_nxt.rx_cnt = s_r.rx_cnt + 4'h1;
                    if (s_r.rx_cnt == `ULCR_TICK_LAST) begin
                        s_nxt.rx_sh[s_r.rx_bit] = rxd;
                        s_nxt.rx_bit = s_r.rx_bit + 3'h1;
                        if (s_r.rx_bit == last_bit) begin
                            s_nxt.rx_st = lcr[`ULCR_LCR_PEN] ? ulcr_pkg::RX_PAR
                                                             : ulcr_pkg::RX_STOP;
                        end
                    end
                end
            end
            ulcr_pkg::RX_PAR: begin
                if (tick) begin
                    s_nxt.rx_cnt = s_r.rx_cnt + 4'h1;
                    if (s_r.rx_cnt == `ULCR_TICK_LAST) begin
                        s_nxt.rx_pb = rxd;
                        s_nxt.rx_st = ulcr_pkg::RX_STOP;
                    end
                end
            end
            ulcr_pkg::RX_STOP: begin
                if (tick) begin
                    s_nxt.rx_cnt = s_r.rx_cnt + 4'h1;
                    if (s_r.rx_cnt == `ULCR_TICK_LAST) begin
                        // Only this first stop bit is checked; extra stops look idle
                        s_nxt.rx_st = ulcr_pkg::RX_IDLE;
                        s_nxt.rx_buffer = s_r.rx_sh;
                        s_nxt.receive_full_flag = 1'b1;
                        if (s_r.receive_full_flag && !clr_ready) begin
                            s_nxt.overrun = 1'b1;
                        end
                        if (!rxd) begin
                            s_nxt.framing_error = 1'b1;
                        end
                        if (lcr[`ULCR_LCR_PEN] && s_r.rx_pb != parity_of(s_r.rx_sh, lcr)) begin
                            s_nxt.parity_err = 1'b1;
                        end
                        if (!rxd && s_r.rx_sh == '0 && !(lcr[`ULCR_LCR_PEN] && s_r.rx_pb)) begin
                            s_nxt.break_ind = 1'b1;
                        end
                    end
                end
            end
            default: s_nxt.rx_st = ulcr_pkg::RX_IDLE;
        endcase

        // Registered ready terms so every bus output comes from a flop
        s_nxt.aw_rdy = !s_nxt.aw_held && !s_nxt.bvalid;
        s_nxt.w_rdy = !s_nxt.w_held && !s_nxt.bvalid;
        s_nxt.ar_rdy = !s_nxt.rvalid;
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_r <= '0;
            s_r.aw_rdy <= 1'b1;
            s_r.w_rdy <= 1'b1;
            s_r.ar_rdy <= 1'b1;
            s_r.tx_st <= ulcr_pkg::TX_IDLE;
            s_r.rx_st <= ulcr_pkg::RX_IDLE;
            s_r.tx_line <= 1'b1; // Idle high
            s_r.txd <= 1'b1;
            s_r.rx_buffer <= `ULCR_RST_BYTE;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign s_axi_awready = s_r.aw_rdy;
    assign s_axi_wready = s_r.w_rdy;
    assign s_axi_bvalid = s_r.bvalid;
    assign s_axi_bresp = s_r.bresp;
    assign s_axi_arready = s_r.ar_rdy;
    assign s_axi_rvalid = s_r.rvalid;
    assign s_axi_rresp = s_r.rresp;
    assign s_axi_rdata = {24'h000000, s_r.rdata};
    assign txd = s_r.txd;

endmodule

`default_nettype wire

// ### verif/test_uart_line_control_regs.sv
// Self-checking bench for the UART register block
`timescale 1ns/10ps
`default_nettype none
module test_uart_line_control_regs;
    logic aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, gpio_pin_five;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, txd, lin_rx, s;
    logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, s_axi_rdata, v;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [7:0] d, g, exp_q[$];
    int err_total = 0, n_checks = 0, cyc = 0;
    ulcr_top u_ulcr_top (.*);
    ulcr_peer u_ulcr_peer (.aclk(aclk), .txd(txd), .rx_line(lin_rx));
    ulcr_peer u_gpio_peer (.aclk(aclk), .txd(1'b1), .rx_line(gpio_pin_five));
    always #5 aclk = ~aclk;
    task chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected %s expected %h seen %h", n, exp, seen);
        end
    endtask
    // Address and data offered together, each dropped once taken
    task wr(input logic [31:0] a, input logic [7:0] x);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, x};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        chk("write response", {30'h0, s_axi_bresp}, 32'h0);
        s_axi_bready <= 1'b0;
        @(posedge aclk);
    endtask
    task rd(input logic [31:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        v = s_axi_rdata | {30'h0, s_axi_rresp} << 30;
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask
    task results;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // Hang guard
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            err_total++;
            results();
        end
    end
    initial begin
        void'($urandom(34234));
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(32'hFFFF0714);
        chk("status reset", v, 32'h60);
        wr(32'hFFFF070C, 8'h80);
        wr(32'hFFFF0700, 8'h01);
        rd(32'hFFFF0700);
        chk("divisor low", v, 32'h1);
        wr(32'hFFFF070C, 8'h03);
        d = 8'($urandom);
        fork
            u_ulcr_peer.recv(g, s);
            wr(32'hFFFF0700, d);
        join
        chk("sent byte", g, d);
        chk("stop bit", s, 1'b1);
        repeat (40) @(posedge aclk);
        rd(32'hFFFF0714);
        chk("status idle", v, 32'h60);
        exp_q.push_back(8'($urandom));
        u_ulcr_peer.send(exp_q[0]);
        rd(32'hFFFF0714);
        chk("status full", v, 32'h61);
        rd(32'hFFFF0700);
        chk("received byte", v, {24'h0, exp_q.pop_front()});
        wr(32'hFFFF0710, 8'h80);
        u_ulcr_peer.send(8'h55);
        rd(32'hFFFF0714);
        chk("unselected input", v, 32'h60);
        exp_q.push_back(8'($urandom));
        u_gpio_peer.send(exp_q[0]);
        rd(32'hFFFF0700);
        chk("gpio byte", v, {24'h0, exp_q.pop_front()});
        wr(32'hFFFF070C, 8'h43);
        chk("break line", txd, 1'b0);
        wr(32'hFFFF0710, 8'h10);
        chk("loopback line", txd, 1'b1);
        wr(32'hFFFF070C, 8'h1B);
        wr(32'hFFFF0700, d);
        repeat (400) @(posedge aclk);
        rd(32'hFFFF0714);
        chk("loop status", v, 32'h61);
        rd(32'hFFFF0700);
        chk("loop byte", v, {24'h0, d});
        rd(32'hFFFF0718);
        chk("unmapped", v, 32'h80000000);
        results();
    end
endmodule
`default_nettype wire

// ### verif/ulcr_peer.sv
// Serial peer driving the receive line and decoding txd
`timescale 1ns/10ps
`default_nettype none
module ulcr_peer (
    input wire logic aclk,
    input wire logic txd,
    output logic rx_line
);
    // Line rests high as if pulled up
    initial rx_line = 1'b1;
    // Start low, data LSB first, one high stop; 32 cycles a bit
    task send(input logic [7:0] d);
        for (int i = 0; i < 10; i++) begin
            rx_line <= i == 0 ? 1'b0 : i == 9 ? 1'b1 : d[i-1];
            repeat (32) @(posedge aclk);
        end
    endtask
    // Mid-bit sampling; s is the first stop bit
    task recv(output logic [7:0] d, output logic s);
        @(negedge txd);
        repeat (16) @(posedge aclk);
        for (int i = 0; i < 9; i++) begin
            repeat (32) @(posedge aclk);
            if (i < 8) d[i] = txd;
            else s = txd;
        end
    endtask
endmodule
`default_nettype wire

// ### verif/ulcr_props.sv
// Bus and line checks bound to the UART register block
`timescale 1ns/10ps
`default_nettype none
module ulcr_props (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic txd
);
    // One clock domain, so one default for all
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("bvalid dropped");
    a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> $stable(s_axi_rdata))
        else $error("rdata moved");
    a_r_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
        else $error("rdata upper set");
    a_aw_block: assert property (s_axi_bvalid |-> !s_axi_awready)
        else $error("awready early");
    a_r_lat: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read late");
    a_b_lat: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##2 s_axi_bvalid) else $error("write late");
    a_ready_back: assert property (s_axi_bvalid && s_axi_bready |=> ##1 s_axi_awready)
        else $error("awready stuck");
    a_txd_idle: assert property ($rose(aresetn) |-> txd)
        else $error("txd low after reset");
    // Main traffic kinds
    cover property (s_axi_bvalid && s_axi_bready);
    cover property (s_axi_rvalid && s_axi_rready);
    cover property ($fell(txd));
endmodule
bind ulcr_top ulcr_props u_ulcr_props (.*);
`default_nettype wire
